// ### rucc_regs.vh
// register offsets, field layouts, reset values and timing counts of the remote update controller
// assumes a plain register port with read data one cycle after the read strobe
//
// How it works
// - remote power-up loads page 000 first
// - failed remote application load falls back to factory
// - only valid remote application may kick watchdog
// - watchdog expiry records cause, reloads factory
// - watchdog is off while factory runs
// - remote application load error records cause, reloads factory
// - clean application load enters user mode
// - at most seven application pages besides factory
// - exactly two modes: remote and local
// - works over serial, sync and async parallel
// - local mode loads single application directly
// - initialization phase precedes user operation
`ifndef RUCC_REGS_VH
`define RUCC_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RUCC_ADDR_CTRL     4'h0
`define RUCC_ADDR_WDT      4'h1
`define RUCC_ADDR_STATUS   4'h2
`define RUCC_ADDR_COUNT    4'h3
`define RUCC_ADDR_CMD      4'h4
`define RUCC_ADDR_KICK     4'h5

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define RUCC_CTRL_PAGE_LSB 0
`define RUCC_CTRL_PAGE_MSB 2
`define RUCC_CTRL_WDEN_BIT 3
`define RUCC_CTRL_RESET    8'h00

// ----------------------------------------------------------------
// command register bits (write only, self clearing)
// ----------------------------------------------------------------
`define RUCC_CMD_LOAD_APP  0
`define RUCC_CMD_LOAD_FAC  1

// ----------------------------------------------------------------
// cause codes held in the status register
// ----------------------------------------------------------------
`define RUCC_CAUSE_NONE    2'h0
`define RUCC_CAUSE_WDT     2'h1
`define RUCC_CAUSE_CFGERR  2'h2
`define RUCC_CAUSE_USER    2'h3

// ----------------------------------------------------------------
// page values and timing
// ----------------------------------------------------------------
`define RUCC_PAGE_FACTORY  3'h0
`define RUCC_WDT_RESET     32'h0000_ffff
`define RUCC_INIT_NS       100
`define RUCC_CLK_NS        5
`define RUCC_INIT_CYCLES   ((`RUCC_INIT_NS + `RUCC_CLK_NS - 1) / `RUCC_CLK_NS)

`endif

// ### rucc_watchdog.v
// user watchdog counter of the remote update controller
// assumes the caller only raises i_kick for a valid remote application
`timescale 1ns/10ps
module rucc_watchdog #(
   parameter WIDTH = 32
) (
   input  wire             i_mclk,
   input  wire             i_resetn,
   input  wire             i_run,       // user mode, enabled, not factory
   input  wire             i_kick,      // accepted kick
   input  wire [WIDTH-1:0] i_timeout,   // programmed timeout in cycles
   output reg              o_expire,    // expiry flag, held high while running with the count at zero
   output reg  [WIDTH-1:0] o_count      // cycles left
);

   // ----------------------------------------------------------------
   // down counter; held full while idle so a fresh run starts full
   // ----------------------------------------------------------------
   always @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_count  <= {WIDTH{1'b0}};
         o_expire <= 1'b0;
      end else if (!i_run) begin
         o_count  <= i_timeout;
         o_expire <= 1'b0;
      end else if (i_kick) begin
         o_count  <= i_timeout;
         o_expire <= 1'b0;
      end else if (o_count == {WIDTH{1'b0}}) begin
         o_expire <= 1'b1;
      end else begin
         o_count  <= o_count - {{(WIDTH-1){1'b0}}, 1'b1};
         o_expire <= 1'b0;
      end
   end

endmodule

// ### rucc_init_timer.v
// initialization phase timer run after each image load
// assumes i_start is a one-cycle pulse
`timescale 1ns/10ps
module rucc_init_timer #(
   parameter CYCLES = 20
) (
   input  wire i_mclk,
   input  wire i_resetn,
   input  wire i_start,   // image finished loading
   output reg  o_done     // one-cycle pulse when init ends
);

   // ----------------------------------------------------------------
   // counts the init phase; registers reset, pins enabled at the end
   // ----------------------------------------------------------------
   reg [15:0] cnt_q;   // cycles left
   reg        busy_q;  // phase running

   always @(posedge i_mclk) begin
      if (!i_resetn) begin
         cnt_q  <= 16'h0000;
         busy_q <= 1'b0;
         o_done <= 1'b0;
      end else if (i_start) begin
         cnt_q  <= CYCLES[15:0];
         busy_q <= 1'b1;
         o_done <= 1'b0;
      end else if (busy_q && cnt_q <= 16'h0001) begin
         busy_q <= 1'b0;
         o_done <= 1'b1;
      end else begin
         cnt_q  <= busy_q ? cnt_q - 16'h0001 : cnt_q;
         o_done <= 1'b0;
      end
   end

endmodule

// ### rucc_top.v
// remote update configuration control: picks the page to load, supervises
// the application with a watchdog and records why a reload happened
// assumes a paged store that answers o_load_req with i_load_done or i_load_err
`timescale 1ns/10ps
`include "rucc_regs.vh"
module rucc_top #(
   parameter PAGE_W      = 3,
   parameter WDT_W       = 32,
   parameter INIT_CYCLES = `RUCC_INIT_CYCLES
) (
   input  wire              i_mclk,
   input  wire              i_resetn,
   // strap pins, taken after reset release
   input  wire              i_local_mode,   // 1: local update mode
   input  wire [1:0]        i_load_scheme,  // 0 serial, 1 sync par, 2 async par
   // register port
   input  wire [3:0]        i_addr,
   input  wire [31:0]       i_wdata,
   input  wire              i_wr,
   input  wire              i_rd,
   output reg  [31:0]       o_rdata,
   // paged store
   output reg               o_load_req,     // one-cycle pulse: fetch page
   output reg  [PAGE_W-1:0] o_page,         // page being loaded
   input  wire              i_load_done,    // image loaded cleanly
   input  wire              i_load_err,     // image load failed
   // application side
   input  wire              i_app_valid,    // image built for remote update
   input  wire              i_app_kick,     // watchdog reset from application
   input  wire              i_app_reload,   // application asks for factory
   output reg               o_user_mode,    // user mode running
   output reg               o_init,         // init phase: registers reset
   output reg               o_io_en,        // user pins enabled
   output reg               o_factory       // factory image active
);

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam ST_STRAP = 3'h0;  // catch straps after reset
   localparam ST_REQ   = 3'h1;  // issue load request
   localparam ST_LOAD  = 3'h2;  // waiting for store
   localparam ST_INIT  = 3'h3;  // init phase
   localparam ST_USER  = 3'h4;  // user mode

   // ----------------------------------------------------------------
   // decode helper, used by both strobes
   // ----------------------------------------------------------------
   function hit;
      input [3:0] a;
      input [3:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg  [2:0]        state_q;     // controller state
   reg               local_q;     // caught mode strap
   reg  [1:0]        scheme_q;    // caught load scheme
   reg  [PAGE_W-1:0] next_page_q; // page chosen by factory logic
   reg               wden_q;      // watchdog wanted for next app
   reg  [WDT_W-1:0]  timeout_q;   // programmed timeout
   reg  [1:0]        cause_q;     // why last reload happened
   reg               err_seen_q;  // sticky load error flag
   reg               wdt_seen_q;  // sticky watchdog flag
   reg               app_cmd_q;   // factory asked to load app
   reg               fac_cmd_q;   // application asked for factory
   reg               kick_reg_q;  // kick via register
   wire              wdt_expire;  // watchdog fired
   wire [WDT_W-1:0]  wdt_count;   // watchdog remaining
   wire              init_done;   // init phase finished
   wire              wdt_run;     // watchdog counting
   wire              kick_ok;     // accepted kick
   wire              wr_cmd;      // command write
   wire              fac_req;     // factory reload request

   // watchdog only in user mode of an application with it enabled
   assign wdt_run = (state_q == ST_USER) && !o_factory && wden_q && !local_q;
   // kicks from anything but a valid remote application are ignored
   assign kick_ok = wdt_run && i_app_valid && (i_app_kick || kick_reg_q);
   assign wr_cmd  = i_wr && hit(i_addr, `RUCC_ADDR_CMD);
   assign fac_req = fac_cmd_q || i_app_reload;

   // ----------------------------------------------------------------
   // sub blocks
   // ----------------------------------------------------------------
   rucc_watchdog #(
      .WIDTH     (WDT_W)
   ) u_wdt (
      .i_mclk    (i_mclk),
      .i_resetn  (i_resetn),
      .i_run     (wdt_run),
      .i_kick    (kick_ok),
      .i_timeout (timeout_q),
      .o_expire  (wdt_expire),
      .o_count   (wdt_count)
   );

   rucc_init_timer #(
      .CYCLES   (INIT_CYCLES)
   ) u_init (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_start  (state_q == ST_LOAD && i_load_done),
      .o_done   (init_done)
   );

   // ----------------------------------------------------------------
   // register writes; status flags: hardware set wins over clear
   // ----------------------------------------------------------------
   always @(posedge i_mclk) begin
      if (!i_resetn) begin
         next_page_q <= `RUCC_PAGE_FACTORY;
         wden_q      <= 1'b0;
         timeout_q   <= `RUCC_WDT_RESET;
         app_cmd_q   <= 1'b0;
         fac_cmd_q   <= 1'b0;
         kick_reg_q  <= 1'b0;
      end else begin
         app_cmd_q  <= wr_cmd && i_wdata[`RUCC_CMD_LOAD_APP];
         fac_cmd_q  <= wr_cmd && i_wdata[`RUCC_CMD_LOAD_FAC];
         kick_reg_q <= i_wr && hit(i_addr, `RUCC_ADDR_KICK);
         // only factory logic may steer the next page and watchdog
         if (i_wr && hit(i_addr, `RUCC_ADDR_CTRL) && o_factory) begin
            next_page_q <= i_wdata[`RUCC_CTRL_PAGE_MSB:`RUCC_CTRL_PAGE_LSB];
            wden_q      <= i_wdata[`RUCC_CTRL_WDEN_BIT];
         end
         if (i_wr && hit(i_addr, `RUCC_ADDR_WDT) && o_factory) begin
            timeout_q <= i_wdata[WDT_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // read port, data valid the cycle after the strobe
   // ----------------------------------------------------------------
   always @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         case (i_addr)
            `RUCC_ADDR_CTRL:   o_rdata <= {28'h0000000, wden_q, next_page_q};
            `RUCC_ADDR_WDT:    o_rdata <= timeout_q;
            `RUCC_ADDR_STATUS: o_rdata <= {21'h000000, scheme_q, local_q, o_factory,
                                          o_page, wdt_seen_q, err_seen_q, cause_q};
            `RUCC_ADDR_COUNT:  o_rdata <= wdt_count;
            default:           o_rdata <= 32'h0000_0000; // unmapped reads zero
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // load controller
   // ----------------------------------------------------------------
   always @(posedge i_mclk) begin
      if (!i_resetn) begin
         state_q     <= ST_STRAP;
         local_q     <= 1'b0;
         scheme_q    <= 2'h0;
         cause_q     <= `RUCC_CAUSE_NONE;
         err_seen_q  <= 1'b0;
         wdt_seen_q  <= 1'b0;
         o_load_req  <= 1'b0;
         o_page      <= `RUCC_PAGE_FACTORY;
         o_user_mode <= 1'b0;
         o_init      <= 1'b0;
         o_io_en     <= 1'b0;
         o_factory   <= 1'b1;
      end else begin
         o_load_req <= 1'b0;
         // a status read clears the sticky flags unless a new event lands
         if (i_rd && hit(i_addr, `RUCC_ADDR_STATUS)) begin
            err_seen_q <= 1'b0;
            wdt_seen_q <= 1'b0;
         end
         case (state_q)
            ST_STRAP: begin
               local_q   <= i_local_mode;
               scheme_q  <= i_load_scheme;
               // local loads its one application; remote starts at factory
               o_page    <= i_local_mode ? {{(PAGE_W-1){1'b0}}, 1'b1}
                                         : `RUCC_PAGE_FACTORY;
               o_factory <= !i_local_mode;
               state_q   <= ST_REQ;
            end
            ST_REQ: begin
               o_load_req  <= 1'b1;
               o_user_mode <= 1'b0;
               o_io_en     <= 1'b0;
               state_q     <= ST_LOAD;
            end
            ST_LOAD: begin
               if (i_load_err) begin
                  if (!o_factory && !local_q) begin
                     cause_q    <= `RUCC_CAUSE_CFGERR;
                     err_seen_q <= 1'b1;
                     o_page     <= `RUCC_PAGE_FACTORY;
                     o_factory  <= 1'b1;
                  end
                  state_q <= ST_REQ;  // retry; a factory or local page stays put
               end else if (i_load_done) begin
                  o_init  <= 1'b1;
                  state_q <= ST_INIT;
               end
            end
            ST_INIT: begin
               if (init_done) begin
                  o_init      <= 1'b0;
                  o_io_en     <= 1'b1;
                  o_user_mode <= 1'b1;
                  state_q     <= ST_USER;
               end
            end
            ST_USER: begin
               if (wdt_expire) begin
                  cause_q    <= `RUCC_CAUSE_WDT;
                  wdt_seen_q <= 1'b1;
                  o_page     <= `RUCC_PAGE_FACTORY;
                  o_factory  <= 1'b1;
                  state_q    <= ST_REQ;
               end else if (o_factory && app_cmd_q && !local_q &&
                            next_page_q != `RUCC_PAGE_FACTORY) begin
                  // factory hands over to the chosen application page
                  o_page    <= next_page_q;
                  o_factory <= 1'b0;
                  state_q   <= ST_REQ;
               end else if (!o_factory && fac_req && !local_q) begin
                  cause_q   <= `RUCC_CAUSE_USER;
                  o_page    <= `RUCC_PAGE_FACTORY;
                  o_factory <= 1'b1;
                  state_q   <= ST_REQ;
               end
            end
            default: begin
               state_q <= ST_STRAP;
            end
         endcase
      end
   end

endmodule

// ### rucc_props.sv
// checker for the remote update controller, bound to rucc_top
// assumes straps stay fixed while reset is released
`timescale 1ns/10ps
module rucc_props #(
   parameter     PAGE_W      = 3,
   parameter int INIT_CYCLES = 20
) (
   input wire              i_mclk,
   input wire              i_resetn,
   input wire              i_local_mode,
   input wire              i_wr,
   input wire              i_rd,
   input wire [31:0]       o_rdata,
   input wire              o_load_req,
   input wire [PAGE_W-1:0] o_page,
   input wire              i_load_done,
   input wire              i_load_err,
   input wire              i_app_reload,
   input wire              o_user_mode,
   input wire              o_init,
   input wire              o_io_en,
   input wire              o_factory
);
   localparam int INIT_HI = INIT_CYCLES + 4;  // slack for the done-to-init edge
   reg in_wait_q;  // a fetch is outstanding at the store

   // track the load-wait window, since done and err count only there
   always @(posedge i_mclk) begin
      if (!i_resetn)
         in_wait_q <= 1'b0;
      else if (o_load_req)
         in_wait_q <= 1'b1;
      else if (i_load_done || i_load_err)
         in_wait_q <= 1'b0;
   end

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_loaded;
      in_wait_q && i_load_done;
   endsequence
   sequence s_user_up;
      o_user_mode && o_io_en && !o_init;
   endsequence

   property p_first_page;
      $rose(i_resetn) && !i_local_mode |-> ##[1:4] (o_load_req && o_page == 0);
   endproperty
   property p_local_first;
      $rose(i_resetn) && i_local_mode |-> ##[1:4] (o_load_req && o_page == 1 && !o_factory);
   endproperty
   property p_err_back;
      in_wait_q && i_load_err && !o_factory && !i_local_mode
         |=> o_factory && o_page == 0 ##[1:3] o_load_req;
   endproperty
   property p_init_after;
      s_loaded |=> o_init && !o_io_en && !o_user_mode;
   endproperty
   property p_user_after;
      s_loaded |=> o_init ##[1:INIT_HI] s_user_up;
   endproperty
   property p_fac_no_wdt;
      o_factory && o_user_mode && !i_wr && !$past(i_wr) |=> o_factory;
   endproperty
   property p_app_page;
      o_load_req && !o_factory |-> o_page != 0;
   endproperty
   property p_fac_page;
      o_load_req && o_factory |-> o_page == 0;
   endproperty
   property p_reload;
      o_user_mode && !o_factory && i_app_reload && !i_local_mode
         |-> ##[1:3] (o_factory && o_page == 0);
   endproperty
   property p_rdata;
      !$past(i_rd) |-> o_rdata == 0;
   endproperty

   a_first_page: assert property (p_first_page)
      else $error("first fetch is not the factory page");
   a_local_first: assert property (p_local_first)
      else $error("local mode did not fetch its application");
   a_err_back: assert property (p_err_back)
      else $error("no factory fallback after load error");
   a_init_after: assert property (p_init_after)
      else $error("init phase missing after load");
   a_user_after: assert property (p_user_after)
      else $error("user mode not reached after init");
   a_fac_no_wdt: assert property (p_fac_no_wdt)
      else $error("factory image left without a command");
   a_app_page: assert property (p_app_page)
      else $error("application fetch uses page zero");
   a_fac_page: assert property (p_fac_page)
      else $error("factory fetch not at page zero");
   a_reload: assert property (p_reload)
      else $error("application reload request ignored");
   a_rdata: assert property (p_rdata)
      else $error("read data not zero outside read slot");
endmodule

bind rucc_top rucc_props #(.PAGE_W(PAGE_W), .INIT_CYCLES(INIT_CYCLES)) props_u (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_local_mode(i_local_mode), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_load_req(o_load_req), .o_page(o_page),
   .i_load_done(i_load_done), .i_load_err(i_load_err), .i_app_reload(i_app_reload),
   .o_user_mode(o_user_mode), .o_init(o_init), .o_io_en(o_io_en), .o_factory(o_factory));

// ### rucc_store_model.sv
// behavioural paged configuration store facing the controller
// assumes one fetch outstanding at a time
`timescale 1ns/10ps
module rucc_store_model (
   input  wire       i_mclk,
   input  wire       i_load_req,  // fetch request pulse
   input  wire [2:0] i_page,      // page to fetch
   input  wire [7:0] i_bad,       // pages holding a corrupt image
   input  wire [3:0] i_delay,     // extra answer latency in cycles
   output reg        o_done,      // clean load pulse
   output reg        o_err        // failed load pulse
);
   reg [4:0] wait_q;  // cycles left before answering
   reg [2:0] page_q;  // page under fetch
   initial begin
      o_done = 1'b0;
      o_err = 1'b0;
      wait_q = 5'h0;
      page_q = 3'h0;
   end
   // answer each fetch once, promptly or slowly as the bench asks
   always @(posedge i_mclk) begin
      o_done <= 1'b0;
      o_err <= 1'b0;
      if (i_load_req) begin
         wait_q <= {1'b0, i_delay} + 5'h1;
         page_q <= i_page;
      end else if (wait_q != 5'h0) begin
         wait_q <= wait_q - 5'h1;
         // the factory page is never overwritten, so it never fails
         if (wait_q == 5'h1 && i_bad[page_q] && page_q != 3'h0)
            o_err <= 1'b1;
         else if (wait_q == 5'h1)
            o_done <= 1'b1;
      end
   end
endmodule

// ### test_remote_update_config_control.sv
// self-checking bench for rucc_top with a paged store model
// assumes a shortened init phase of four cycles
`timescale 1ns/10ps
`include "rucc_regs.vh"
module test_remote_update_config_control;
   localparam int EV_INI = 0;  // bit positions in evs
   localparam int EV_USR = 1;
   localparam int EV_FAC = 2;
   localparam int EV_REQ = 3;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic        local_md = 1'b0;
   logic [1:0]  scheme = 2'h0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        app_valid = 1'b0;
   logic        kick = 1'b0;
   logic        reload = 1'b0;
   logic [7:0]  bad = 8'h00;
   logic [3:0]  delay = 4'h0;
   logic [31:0] rv;
   wire  [31:0] rdata;
   wire  [2:0]  page;
   wire         load_req, done, err, user, init, io_en, factory;
   wire  [3:0]  evs = {load_req, factory, user, init};
   int          n_errors = 0;
   int          comparisons = 0;

   always #2.5 mclk = ~mclk;

   rucc_top #(.INIT_CYCLES(4)) dut_u (
      .i_mclk(mclk), .i_resetn(resetn), .i_local_mode(local_md), .i_load_scheme(scheme),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_load_req(load_req), .o_page(page), .i_load_done(done), .i_load_err(err),
      .i_app_valid(app_valid), .i_app_kick(kick), .i_app_reload(reload),
      .o_user_mode(user), .o_init(init), .o_io_en(io_en), .o_factory(factory));
   rucc_store_model store_u (
      .i_mclk(mclk), .i_load_req(load_req), .i_page(page), .i_bad(bad),
      .i_delay(delay), .o_done(done), .o_err(err));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask
   // bounded wait for one status output to reach a level
   task automatic wt(input int b, input logic v, input int lim);
      int k;
      k = 0;
      while (evs[b] !== v && k < lim) begin
         @(posedge mclk);
         #1 k++;
      end
      check(32'(evs[b]), 32'(v));
   endtask
   task automatic do_reset(input logic lm, input logic [1:0] sc);
      @(posedge mclk);
      resetn <= 1'b0;
      local_md <= lm;
      scheme <= sc;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      #1;
   endtask
   task automatic kicks(input int n, input int gap);
      repeat (n) begin
         repeat (gap) @(posedge mclk);
         kick <= 1'b1;
         @(posedge mclk);
         kick <= 1'b0;
      end
      #1;
   endtask
   task automatic launch(input logic [2:0] p, input logic wd);
      reg_wr(`RUCC_ADDR_CTRL, {28'h0, wd, p});
      reg_wr(`RUCC_ADDR_CMD, 32'h1);
      wt(EV_REQ, 1'b1, 12);
      check(32'({page, factory}), {28'h0, p, 1'b0});
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power_up;
      for (int s = 0; s < 3; s++) begin
         delay <= 4'(s * 4);  // prompt, then slower store answers
         do_reset(1'b0, 2'(s));
         wt(EV_REQ, 1'b1, 12);
         check(32'(page), 32'h0);
         wt(EV_INI, 1'b1, 40);
         check(32'(io_en), 32'h0);
         wt(EV_USR, 1'b1, 40);
         check(32'({io_en, factory}), 32'h3);
         reg_rd(`RUCC_ADDR_STATUS);
         check(rv & 32'h6f0, {21'h0, 2'(s), 9'h080});
         reg_rd(4'hf);
         check(rv, 32'h0);
      end
   endtask
   task automatic t_app_err;
      bad <= 8'h08;
      launch(3'h3, 1'b0);
      wt(EV_FAC, 1'b1, 30);
      wt(EV_USR, 1'b1, 60);
      reg_rd(`RUCC_ADDR_STATUS);
      check(rv & 32'hff, {24'h0, 6'h21, `RUCC_CAUSE_CFGERR});
      reg_rd(`RUCC_ADDR_STATUS);
      check(32'(rv[3:2]), 32'h0);
      bad <= 8'h00;
   endtask
   task automatic t_pages;
      for (int p = 1; p < 8; p++) begin
         launch(3'(p), 1'b0);
         wt(EV_USR, 1'b1, 60);
         reg_wr(`RUCC_ADDR_CTRL, 32'h5);  // refused outside factory
         @(posedge mclk);
         reload <= 1'b1;
         @(posedge mclk);
         reload <= 1'b0;
         #1;
         wt(EV_FAC, 1'b1, 8);
         wt(EV_USR, 1'b0, 8);
         wt(EV_USR, 1'b1, 60);
         reg_rd(`RUCC_ADDR_STATUS);
         check(32'(rv[1:0]), 32'(`RUCC_CAUSE_USER));
         reg_rd(`RUCC_ADDR_CTRL);
         check(32'(rv[3:0]), 32'(p));
      end
   endtask
   task automatic t_wdt;
      reg_wr(`RUCC_ADDR_WDT, 32'ha);
      launch(3'h2, 1'b1);
      wt(EV_USR, 1'b1, 60);
      app_valid <= 1'b1;
      kicks(5, 6);
      reg_rd(`RUCC_ADDR_COUNT);
      check(32'(rv > 32'h5 && rv <= 32'ha), 32'h1);
      check(32'({user, factory}), 32'h2);
      app_valid <= 1'b0;
      kicks(8, 3);  // these must not hold the counter off
      check(32'(factory), 32'h1);
      wt(EV_USR, 1'b1, 60);
      reg_rd(`RUCC_ADDR_STATUS);
      check(rv & 32'hff, {24'h0, 6'h22, `RUCC_CAUSE_WDT});
      repeat (40) @(posedge mclk);
      #1;
      check(32'({user, factory}), 32'h3);
   endtask
   task automatic t_local;
      do_reset(1'b1, 2'h1);
      wt(EV_REQ, 1'b1, 12);
      check(32'({page, factory}), 32'h2);
      wt(EV_USR, 1'b1, 60);
      reg_rd(`RUCC_ADDR_STATUS);
      check(32'(rv[8]), 32'h1);
   endtask

   task automatic give_verdict;
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog: the whole run needs several hundred cycles, the limit is 10000
   initial begin
      #50us;
      n_errors++;
      give_verdict();
   end
   initial begin
      t_power_up();
      t_app_err();
      t_pages();
      t_wdt();
      t_local();
      give_verdict();
   end
endmodule
